// File: entropy_setup_pkg.sv
// Functional notes
// R1 - four DC predictors, chosen per block by high and low sequence bits
// R2 - host loads predictor sequences per mode, e.g. 4:2:2 low 0x044, high 0x088
// R3 - host loads the same predictor sequences for coding and decoding
// R4 - any write to the predictor clear register zeroes all four predictors
// R5 - after end-of-image in decoding, host clears predictors before restarting
// R6 - host writes zero into every unused code table entry
// R7 - code table writes land only while load enable is set; host clears it
// R8 - luminance or chrominance table per block follows table sequence bits
// R9 - end-of-block on every block when forced, else only after zero last coefficient
// R10 - least significant bit first output when that attribute bit is set
// R11 - restart enable inserts a restart marker at each interval end
// R12 - attribute bits 3..0 give blocks per minimum coded unit
// R13 - high and low interval bytes form a 16-bit units-per-interval count
// R14 - restart placement counts coded units against the programmed interval
// R15 - unit spans 16x8 pixels in 4:2:2 modes, 8x8 otherwise, via block count
// R16 - image end emits 0xFFD9, or a restart marker when sync bit 10 is set
// R17 - host loads sync bits 9..0 with the mode value at start-up
// R18 - reserved bits read zero and ignore writes
package entropy_setup_pkg;
   // register offsets on the host bus
   localparam logic [15:0] REG_LOAD_EN = 16'h9004;
   localparam logic [15:0] REG_TBL_SEQ = 16'hA000;
   localparam logic [15:0] REG_PSEQ_HI = 16'hA004;
   localparam logic [15:0] REG_PSEQ_LO = 16'hA008;
   localparam logic [15:0] REG_ATTR = 16'hA00C;
   localparam logic [15:0] REG_IVL_HI = 16'hA010;
   localparam logic [15:0] REG_IVL_LO = 16'hA014;
   localparam logic [15:0] REG_SYNC = 16'hA020;
   localparam logic [15:0] REG_PCLR = 16'hA818;
   localparam logic [15:0] TBL_BASE = 16'hE000;
   localparam logic [15:0] TBL_LAST = 16'hFC7C;
   localparam int TBL_ENTRIES = 1824;
   // implemented bits of each register
   localparam logic [15:0] LOAD_MASK = 16'h0001;
   localparam logic [15:0] SEQ_MASK = 16'h00FF;
   localparam logic [15:0] ATTR_MASK = 16'h007F;
   localparam logic [15:0] IVL_MASK = 16'h00FF;
   localparam logic [15:0] SYNC_MASK = 16'h07FF;
   // field positions
   localparam int ATTR_EOB_BIT = 6;
   localparam int ATTR_LSB_BIT = 5;
   localparam int ATTR_RST_BIT = 4;
   localparam int SYNC_SEL_BIT = 10;
   localparam int SYNC_PAT_W = 10;
   localparam int PRED_COUNT = 4;
   localparam int SEQ_BITS = 8;
   // values after reset and marker codes
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] MARK_EOI = 16'hFFD9;
   localparam logic [15:0] MARK_RST_BASE = 16'hFFD0;
endpackage

// File: two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
   parameter int WIDTH = 12
) (
   input wire logic clk_i, // device clock
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic in_valid_i, // word offered
   output logic in_ready_o, // room for a word
   input wire logic [WIDTH-1:0] in_data_i, // word in
   output logic out_valid_o, // word held
   input wire logic out_ready_i, // receiver takes the word
   output logic [WIDTH-1:0] out_data_o // oldest word
);
   logic [1:0] count_q, count_d;
   logic [WIDTH-1:0] slot0_q, slot0_d, slot1_q, slot1_d;
   logic push, pop;

   // full only at two, so a stalled receiver never loses a word
   assign in_ready_o = (count_q != 2'h2);
   assign out_valid_o = (count_q != 2'h0);
   assign out_data_o = slot0_q;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   // shift on pop, then write behind the remaining word
   always_comb begin
      count_d = count_q;
      slot0_d = slot0_q;
      slot1_d = slot1_q;
      if (pop) begin
         slot0_d = slot1_q;
      end
      if (push) begin
         if ((count_q == 2'h0) || (count_q == 2'h1 && pop)) begin
            slot0_d = in_data_i;
         end else begin
            slot1_d = in_data_i;
         end
      end
      count_d = count_q + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         count_q <= 2'h0;
         slot0_q <= '0;
         slot1_q <= '0;
      end else begin
         count_q <= count_d;
         slot0_q <= slot0_d;
         slot1_q <= slot1_d;
      end
   end
endmodule // two_entry_buffer
`default_nettype wire

// File: entropy_coder_setup.sv
`timescale 1ns/1ps
`default_nettype none
module entropy_coder_setup
   import entropy_setup_pkg::*;
#(
   parameter int CODE_W = 12,
   parameter int DEPTH = TBL_ENTRIES,
   parameter int LK_W = 11
) (
   input wire logic clk_i, // device clock, 20 MHz
   input wire logic rst_n_i, // synchronous reset, active low
   input wire logic [15:0] host_addr_i, // register byte address
   input wire logic [15:0] host_wdata_i, // write data
   input wire logic host_wr_i, // write strobe, one cycle
   input wire logic host_rd_i, // read strobe, one cycle
   output logic [15:0] host_rdata_o, // read data, next cycle
   input wire logic image_start_i, // new image, restarts counting
   input wire logic block_done_i, // coder finished one block
   input wire logic image_end_i, // coder reached image end
   input wire logic last_coef_zero_i, // current block ends in zero
   input wire logic dc_write_i, // store new DC value
   input wire logic [15:0] dc_value_i, // DC value to store
   output logic [1:0] pred_sel_o, // active predictor index
   output logic [15:0] dc_pred_o, // active predictor value
   output logic chroma_table_o, // 1 = chrominance tables
   output logic eob_append_o, // append end-of-block code
   output logic lsb_first_o, // serialise lsb first
   output logic [SYNC_PAT_W-1:0] sync_pattern_o, // stream sync value
   output logic table_write_enable_o, // code table open to host
   output logic marker_valid_o, // marker pulse
   output logic [15:0] marker_code_o, // marker word
   input wire logic lk_valid_i, // code lookup request
   output logic lk_ready_o, // lookup taken
   input wire logic [LK_W-1:0] lk_addr_i, // table entry index
   output logic code_valid_o, // lookup result held
   input wire logic code_ready_i, // result taken
   output logic [CODE_W-1:0] code_data_o // code table value
);
   // refuse shapes the logic cannot serve
   generate
      if (CODE_W < 1 || CODE_W > 16) begin : g_bad_code_w
         $error("CODE_W must be 1..16");
      end
      if (DEPTH < 1 || DEPTH > TBL_ENTRIES || (1 << LK_W) < DEPTH) begin : g_bad_depth
         $error("DEPTH must fit the table window and LK_W");
      end
   endgenerate

   // ---------------- host registers ----------------
   logic load_en_q, load_en_d;
   logic [15:0] tbl_seq_q, tbl_seq_d, pseq_hi_q, pseq_hi_d, pseq_lo_q, pseq_lo_d;
   logic [15:0] attr_q, attr_d, ivl_hi_q, ivl_hi_d, ivl_lo_q, ivl_lo_d, sync_q, sync_d;
   logic [15:0] rdata_q, rdata_d;
   logic pclr_hit, tbl_hit;
   logic [15:0] tbl_off;
   logic [LK_W-1:0] tbl_idx;
   logic [CODE_W-1:0] mem [DEPTH];

   // code table window: word aligned, base through last entry
   assign tbl_off = host_addr_i - TBL_BASE;
   assign tbl_idx = tbl_off[LK_W+1:2];
   assign tbl_hit = (host_addr_i >= TBL_BASE) && (host_addr_i <= TBL_LAST)
                    && (host_addr_i[1:0] == 2'h0) && (int'(tbl_idx) < DEPTH);
   assign pclr_hit = host_wr_i && (host_addr_i == REG_PCLR); // R4

   // register writes keep only implemented bits
   always_comb begin
      load_en_d = load_en_q;
      tbl_seq_d = tbl_seq_q;
      pseq_hi_d = pseq_hi_q;
      pseq_lo_d = pseq_lo_q;
      attr_d = attr_q;
      ivl_hi_d = ivl_hi_q;
      ivl_lo_d = ivl_lo_q;
      sync_d = sync_q;
      rdata_d = rdata_q;
      if (host_wr_i) begin
         unique case (host_addr_i)
            REG_LOAD_EN: load_en_d = host_wdata_i[0]; // R7
            REG_TBL_SEQ: tbl_seq_d = host_wdata_i & SEQ_MASK; // R18
            REG_PSEQ_HI: pseq_hi_d = host_wdata_i & SEQ_MASK; // R1
            REG_PSEQ_LO: pseq_lo_d = host_wdata_i & SEQ_MASK; // R1
            REG_ATTR: attr_d = host_wdata_i & ATTR_MASK; // R18
            REG_IVL_HI: ivl_hi_d = host_wdata_i & IVL_MASK; // R13
            REG_IVL_LO: ivl_lo_d = host_wdata_i & IVL_MASK; // R13
            REG_SYNC: sync_d = host_wdata_i & SYNC_MASK; // R18
            default: ;
         endcase
      end
      // reads answer one cycle later; unmapped and write-only read zero
      if (host_rd_i) begin
         unique case (host_addr_i)
            REG_LOAD_EN: rdata_d = {15'h0000, load_en_q};
            REG_TBL_SEQ: rdata_d = tbl_seq_q;
            REG_PSEQ_HI: rdata_d = pseq_hi_q;
            REG_PSEQ_LO: rdata_d = pseq_lo_q;
            REG_ATTR: rdata_d = attr_q;
            REG_IVL_HI: rdata_d = ivl_hi_q;
            REG_IVL_LO: rdata_d = ivl_lo_q;
            REG_SYNC: rdata_d = sync_q;
            default: rdata_d = tbl_hit ? 16'(mem[tbl_idx]) : 16'h0000; // R18
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         load_en_q <= 1'b0;
         tbl_seq_q <= REG_RESET;
         pseq_hi_q <= REG_RESET;
         pseq_lo_q <= REG_RESET;
         attr_q <= REG_RESET;
         ivl_hi_q <= REG_RESET;
         ivl_lo_q <= REG_RESET;
         sync_q <= REG_RESET;
         rdata_q <= REG_RESET;
      end else begin
         load_en_q <= load_en_d;
         tbl_seq_q <= tbl_seq_d;
         pseq_hi_q <= pseq_hi_d;
         pseq_lo_q <= pseq_lo_d;
         attr_q <= attr_d;
         ivl_hi_q <= ivl_hi_d;
         ivl_lo_q <= ivl_lo_d;
         sync_q <= sync_d;
         rdata_q <= rdata_d;
      end
   end

   assign host_rdata_o = rdata_q;
   assign table_write_enable_o = load_en_q;
   assign lsb_first_o = attr_q[ATTR_LSB_BIT]; // R10
   assign sync_pattern_o = sync_q[SYNC_PAT_W-1:0];
   // forced end-of-block, or only after a zero last coefficient
   assign eob_append_o = attr_q[ATTR_EOB_BIT] | last_coef_zero_i; // R9

   // ---------------- code table memory ----------------
   // no reset on the array: host must load every entry, zeros included
   always_ff @(posedge clk_i) begin
      if (host_wr_i && tbl_hit && load_en_q) begin // R7
         mem[tbl_idx] <= host_wdata_i[CODE_W-1:0];
      end
   end

   // lookup stage feeding the buffer; holds while the buffer is full
   logic pend_q, pend_d;
   logic [CODE_W-1:0] look_q, look_d;
   logic buf_ready;
   assign lk_ready_o = !pend_q || buf_ready;

   always_comb begin
      pend_d = pend_q;
      look_d = look_q;
      if (pend_q && buf_ready) begin
         pend_d = 1'b0;
      end
      if (lk_valid_i && lk_ready_o) begin
         pend_d = 1'b1;
         look_d = (int'(lk_addr_i) < DEPTH) ? mem[lk_addr_i] : '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pend_q <= 1'b0;
         look_q <= '0;
      end else begin
         pend_q <= pend_d;
         look_q <= look_d;
      end
   end

   two_entry_buffer #(.WIDTH(CODE_W)) u_code_buf (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(pend_q),
      .in_ready_o(buf_ready),
      .in_data_i(look_q),
      .out_valid_o(code_valid_o),
      .out_ready_i(code_ready_i),
      .out_data_o(code_data_o)
   );

   // ---------------- block sequencing ----------------
   logic [3:0] blk_q, blk_d;
   logic [15:0] unit_q, unit_d;
   logic [2:0] rst_num_q, rst_num_d;
   logic mk_valid_q, mk_valid_d;
   logic [15:0] mk_code_q, mk_code_d;
   logic [15:0] pred_q [PRED_COUNT];
   logic [15:0] pred_d [PRED_COUNT];
   logic [15:0] interval;
   logic [3:0] unit_blocks;
   logic unit_end, restart_now, seq_in_range;

   assign interval = {ivl_hi_q[7:0], ivl_lo_q[7:0]}; // R13
   // a 4:2:2 unit (16x8) holds four blocks, an 8x8 unit fewer
   assign unit_blocks = attr_q[3:0]; // R12 R15
   assign seq_in_range = (blk_q < 4'(SEQ_BITS));
   // sequence bit n steers block n of the unit
   assign pred_sel_o = seq_in_range ? {pseq_hi_q[blk_q[2:0]], pseq_lo_q[blk_q[2:0]]}
                                    : 2'h0; // R1
   assign chroma_table_o = seq_in_range && tbl_seq_q[blk_q[2:0]]; // R8
   assign dc_pred_o = pred_q[pred_sel_o];
   // zero blocks per unit is treated as one
   assign unit_end = block_done_i && ({1'b0, blk_q} + 5'h01 >= {1'b0, unit_blocks});
   // interval of zero never places a marker
   assign restart_now = unit_end && attr_q[ATTR_RST_BIT] && (interval != 16'h0000)
                        && (unit_q + 16'h0001 == interval); // R11 R14

   always_comb begin
      blk_d = blk_q;
      unit_d = unit_q;
      rst_num_d = rst_num_q;
      mk_valid_d = 1'b0;
      mk_code_d = mk_code_q;
      pred_d = pred_q;
      if (block_done_i) begin
         blk_d = unit_end ? 4'h0 : blk_q + 4'h1;
      end
      if (unit_end) begin
         unit_d = restart_now ? 16'h0000 : unit_q + 16'h0001; // R14
      end
      if (restart_now) begin
         mk_valid_d = 1'b1;
         mk_code_d = MARK_RST_BASE | {13'h0000, rst_num_q}; // R11
         rst_num_d = rst_num_q + 3'h1;
      end
      // end marker takes the port over a restart in the same cycle
      if (image_end_i) begin
         mk_valid_d = 1'b1;
         if (sync_q[SYNC_SEL_BIT]) begin
            mk_code_d = MARK_RST_BASE | {13'h0000, rst_num_q}; // R16
         end else begin
            mk_code_d = MARK_EOI; // R16
         end
      end
      if (image_start_i) begin
         blk_d = 4'h0;
         unit_d = 16'h0000;
         rst_num_d = 3'h0;
      end
      if (dc_write_i) begin
         pred_d[pred_sel_o] = dc_value_i;
      end
      // clearing wins over a same-cycle store
      if (pclr_hit) begin
         for (int i = 0; i < PRED_COUNT; i++) begin
            pred_d[i] = 16'h0000; // R4
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         blk_q <= 4'h0;
         unit_q <= 16'h0000;
         rst_num_q <= 3'h0;
         mk_valid_q <= 1'b0;
         mk_code_q <= 16'h0000;
         for (int i = 0; i < PRED_COUNT; i++) begin
            pred_q[i] <= 16'h0000;
         end
      end else begin
         blk_q <= blk_d;
         unit_q <= unit_d;
         rst_num_q <= rst_num_d;
         mk_valid_q <= mk_valid_d;
         mk_code_q <= mk_code_d;
         pred_q <= pred_d;
      end
   end

   assign marker_valid_o = mk_valid_q;
   assign marker_code_o = mk_code_q;
endmodule // entropy_coder_setup
`default_nettype wire

// File: entropy_setup_props.sv
`timescale 1ns/1ps
`default_nettype none
module entropy_setup_props
   import entropy_setup_pkg::*;
#(
   parameter int CODE_W = 12
) (
   input wire logic clk_i, // device clock
   input wire logic rst_n_i, // synchronous reset
   input wire logic [15:0] host_addr_i, // register address
   input wire logic [15:0] host_wdata_i, // write data
   input wire logic host_wr_i, // write strobe
   input wire logic host_rd_i, // read strobe
   input wire logic [15:0] host_rdata_o, // read data
   input wire logic image_end_i, // image end pulse
   input wire logic last_coef_zero_i, // block ends in zero
   input wire logic [15:0] dc_pred_o, // active predictor
   input wire logic eob_append_o, // end-of-block request
   input wire logic lsb_first_o, // bit order
   input wire logic [SYNC_PAT_W-1:0] sync_pattern_o, // sync value
   input wire logic table_write_enable_o, // load enable
   input wire logic marker_valid_o, // marker pulse
   input wire logic [15:0] marker_code_o, // marker word
   input wire logic code_valid_o, // result held
   input wire logic code_ready_i, // result taken
   input wire logic [CODE_W-1:0] code_data_o // result word
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // register loads reach the outputs one edge later
   chk_lsb_order: assert property (host_wr_i && host_addr_i == REG_ATTR
      |=> lsb_first_o == $past(host_wdata_i[ATTR_LSB_BIT])) else $error("bit order wrong");
   chk_load_gate: assert property (host_wr_i && host_addr_i == REG_LOAD_EN
      |=> table_write_enable_o == $past(host_wdata_i[0])) else $error("load enable wrong");
   chk_sync_load: assert property (host_wr_i && host_addr_i == REG_SYNC
      |=> sync_pattern_o == $past(host_wdata_i[SYNC_PAT_W-1:0])) else $error("sync wrong");
   chk_eob_zero: assert property (last_coef_zero_i |-> eob_append_o)
      else $error("end-of-block missing");
   chk_eob_plain: assert property (host_wr_i && host_addr_i == REG_ATTR
      && !host_wdata_i[ATTR_EOB_BIT] ##1 !last_coef_zero_i |-> !eob_append_o)
      else $error("end-of-block not expected");
   chk_pred_clear: assert property (host_wr_i && host_addr_i == REG_PCLR
      |=> dc_pred_o == 16'h0000) else $error("predictor not cleared");
   chk_clear_read: assert property (host_rd_i && host_addr_i == REG_PCLR
      |=> host_rdata_o == 16'h0000) else $error("clear register reads nonzero");
   // markers: end marker on the next edge, codes only from the two families
   chk_end_marker: assert property (image_end_i |=> marker_valid_o)
      else $error("end marker missing");
   chk_marker_range: assert property (marker_valid_o |-> marker_code_o == MARK_EOI
      || marker_code_o[15:3] == MARK_RST_BASE[15:3]) else $error("bad marker code");
   chk_marker_hold: assert property (!marker_valid_o |-> $stable(marker_code_o))
      else $error("marker word moved");
   // a stalled result must not be lost or changed
   chk_code_hold: assert property (code_valid_o && !code_ready_i
      |=> code_valid_o && $stable(code_data_o)) else $error("result dropped");
endmodule // entropy_setup_props
bind entropy_coder_setup entropy_setup_props #(.CODE_W(CODE_W)) entropy_setup_props_inst (
   .clk_i, .rst_n_i, .host_addr_i, .host_wdata_i, .host_wr_i, .host_rd_i, .host_rdata_o,
   .image_end_i, .last_coef_zero_i, .dc_pred_o, .eob_append_o, .lsb_first_o,
   .sync_pattern_o, .table_write_enable_o, .marker_valid_o, .marker_code_o,
   .code_valid_o, .code_ready_i, .code_data_o);
`default_nettype wire

// File: host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
   import entropy_setup_pkg::*;
(
   input wire logic clk_i, // device clock
   output logic [15:0] host_addr_o, // register address
   output logic [15:0] host_wdata_o, // write data
   output logic host_wr_o, // write strobe
   output logic host_rd_o, // read strobe
   input wire logic [15:0] host_rdata_i // read data
);
   // idle bus at time zero
   initial begin
      host_addr_o = 16'h0000;
      host_wdata_o = 16'h0000;
      host_wr_o = 1'b0;
      host_rd_o = 1'b0;
   end
   // released lines show inverted values so stale data never matches
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      host_addr_o <= a;
      host_wdata_o <= d;
      host_wr_o <= 1'b1;
      @(posedge clk_i);
      host_wr_o <= 1'b0;
      host_addr_o <= ~a;
      host_wdata_o <= ~d;
   endtask
   // read word is taken one edge after the strobe edge
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk_i);
      host_addr_o <= a;
      host_rd_o <= 1'b1;
      @(posedge clk_i);
      host_rd_o <= 1'b0;
      host_addr_o <= ~a;
      @(posedge clk_i);
      d = host_rdata_i;
   endtask
   // same values for coding and decoding
   task automatic load_mode(input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] s);
      wr(REG_PSEQ_LO, lo);
      wr(REG_PSEQ_HI, hi);
      wr(REG_SYNC, s);
   endtask
   // every entry zeroed, load window closed afterwards
   task automatic zero_table();
      wr(REG_LOAD_EN, 16'h0001);
      for (int i = 0; i < TBL_ENTRIES; i++) wr(TBL_BASE + 16'(i * 4), 16'h0000);
      wr(REG_LOAD_EN, 16'h0000);
   endtask
endmodule // host_model
`default_nettype wire

// File: entropy_coder_setup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module entropy_coder_setup_tb
   import entropy_setup_pkg::*;
;
   logic clk_i, rst_n_i, host_wr_i, host_rd_i, image_start_i, block_done_i, image_end_i;
   logic last_coef_zero_i, dc_write_i, chroma_table_o, eob_append_o, lsb_first_o;
   logic table_write_enable_o, marker_valid_o, lk_valid_i, lk_ready_o, code_valid_o;
   logic code_ready_i;
   logic [15:0] host_addr_i, host_wdata_i, host_rdata_o, dc_value_i, dc_pred_o, marker_code_o;
   logic [15:0] rd_q;
   logic [15:0] marks[$];
   logic [1:0] pred_sel_o;
   logic [9:0] sync_pattern_o;
   logic [10:0] lk_addr_i;
   logic [11:0] code_data_o;
   int errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   // address, write data, read-back value
   logic [15:0] rows [10][3] = '{'{REG_LOAD_EN, 16'hFFFF, 16'h0001},
      '{REG_TBL_SEQ, 16'hFFCC, 16'h00CC}, '{REG_PSEQ_HI, 16'h0088, 16'h0088},
      '{REG_PSEQ_LO, 16'h0044, 16'h0044}, '{REG_ATTR, 16'hFFFF, 16'h007F},
      '{REG_IVL_HI, 16'h1200, 16'h0000}, '{REG_IVL_LO, 16'h010F, 16'h000F},
      '{REG_SYNC, 16'hFDC0, 16'h05C0}, '{REG_PCLR, 16'h0001, 16'h0000},
      '{16'h9008, 16'h1234, 16'h0000}};
   logic [1:0] exp_sel [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
   logic exp_c [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   entropy_coder_setup entropy_coder_setup_inst (.clk_i, .rst_n_i, .host_addr_i,
      .host_wdata_i, .host_wr_i, .host_rd_i, .host_rdata_o, .image_start_i, .block_done_i,
      .image_end_i, .last_coef_zero_i, .dc_write_i, .dc_value_i, .pred_sel_o, .dc_pred_o,
      .chroma_table_o, .eob_append_o, .lsb_first_o, .sync_pattern_o, .table_write_enable_o,
      .marker_valid_o, .marker_code_o, .lk_valid_i, .lk_ready_o, .lk_addr_i, .code_valid_o,
      .code_ready_i, .code_data_o);
   host_model host_model_inst (.clk_i, .host_addr_o(host_addr_i), .host_wdata_o(host_wdata_i),
      .host_wr_o(host_wr_i), .host_rd_o(host_rd_i), .host_rdata_i(host_rdata_o));
   // clock at 50 ns
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // marker capture and hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (marker_valid_o === 1'b1) marks.push_back(marker_code_o);
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // start, block done, image end, dc write as one-cycle pulses
   task automatic pulse(input logic [3:0] s);
      @(posedge clk_i);
      {image_start_i, block_done_i, image_end_i, dc_write_i} <= s;
      @(posedge clk_i);
      {image_start_i, block_done_i, image_end_i, dc_write_i} <= 4'h0;
      #1;
   endtask
   task automatic results();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      rst_n_i = 1'b0;
      {image_start_i, block_done_i, image_end_i, dc_write_i} = 4'h0;
      {last_coef_zero_i, lk_valid_i, code_ready_i} = 3'b000;
      dc_value_i = 16'h0055;
      lk_addr_i = 11'd5;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin
         host_model_inst.rd(rows[i][0], rd_q);
         check_word(rd_q, 16'h0000);
      end
      $display("test reset values done");
      foreach (rows[i]) begin
         host_model_inst.wr(rows[i][0], rows[i][1]);
         host_model_inst.rd(rows[i][0], rd_q);
         check_word(rd_q, rows[i][2]);
      end
      $display("test register access done");
      // table writes gated by load enable, reserved bits dropped
      host_model_inst.zero_table();
      host_model_inst.wr(REG_LOAD_EN, 16'h0001);
      host_model_inst.wr(TBL_BASE + 16'h0014, 16'hF123);
      host_model_inst.wr(REG_LOAD_EN, 16'h0000);
      host_model_inst.wr(TBL_BASE + 16'h0014, 16'h0ABC);
      host_model_inst.rd(TBL_BASE + 16'h0014, rd_q);
      check_word(rd_q, 16'h0123);
      // fill lookups against a stalled receiver, then drain
      lk_valid_i <= 1'b1;
      n = 0;
      repeat (8) begin
         @(posedge clk_i);
         if (lk_ready_o === 1'b1) n++;
      end
      check_word({15'h0000, lk_ready_o}, 16'h0000);
      lk_valid_i <= 1'b0;
      code_ready_i <= 1'b1;
      repeat (n) begin
         do @(posedge clk_i); while (code_valid_o !== 1'b1);
         check_word({4'h0, code_data_o}, 16'h0123);
      end
      code_ready_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check_word({15'h0000, code_valid_o}, 16'h0000);
      $display("test code table done");
      // 4:2:2 walk: four blocks to a unit, predictor and table per block
      host_model_inst.load_mode(16'h0044, 16'h0088, 16'h01C0);
      host_model_inst.wr(REG_TBL_SEQ, 16'h00CC);
      host_model_inst.wr(REG_ATTR, 16'h0004);
      pulse(4'b1000);
      check_word({15'h0000, eob_append_o}, 16'h0000);
      // unforced: end-of-block only behind a zero last coefficient
      @(posedge clk_i);
      last_coef_zero_i <= 1'b1;
      #1;
      check_word({15'h0000, eob_append_o}, 16'h0001);
      @(posedge clk_i);
      last_coef_zero_i <= 1'b0;
      pulse(4'b0001);
      check_word(dc_pred_o, 16'h0055);
      host_model_inst.wr(REG_PCLR, 16'h0000);
      // the clear lands on the write edge, so look just after it
      #1;
      check_word(dc_pred_o, 16'h0000);
      for (int b = 0; b < 5; b++) begin
         check_word({14'h0000, pred_sel_o}, {14'h0000, exp_sel[b]});
         check_word({15'h0000, chroma_table_o}, {15'h0000, exp_c[b]});
         pulse(4'b0100);
      end
      $display("test block sequence done");
      // restart every two units, then both end marker kinds
      host_model_inst.wr(REG_ATTR, 16'h0051);
      host_model_inst.wr(REG_IVL_HI, 16'h0000);
      host_model_inst.wr(REG_IVL_LO, 16'h0002);
      check_word({15'h0000, eob_append_o}, 16'h0001);
      pulse(4'b1000);
      repeat (4) pulse(4'b0100);
      host_model_inst.wr(REG_SYNC, 16'h05C0);
      pulse(4'b0010);
      host_model_inst.wr(REG_SYNC, 16'h01C0);
      pulse(4'b0010);
      // after the end marker the host clears the predictors before going on
      pulse(4'b0001);
      host_model_inst.wr(REG_PCLR, 16'h0001);
      #1;
      check_word(dc_pred_o, 16'h0000);
      // high byte counts: 258 units, so four blocks give no marker
      host_model_inst.wr(REG_IVL_HI, 16'h0001);
      pulse(4'b1000);
      repeat (4) pulse(4'b0100);
      check_word(16'(marks.size()), 16'h0004);
      foreach (marks[i]) check_word(marks[i], i < 3 ? MARK_RST_BASE + 16'(i) : MARK_EOI);
      $display("test markers done");
      // mid-run reset empties the registers and the marker word again
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      #1;
      check_word(marker_code_o, 16'h0000);
      host_model_inst.rd(REG_SYNC, rd_q);
      check_word(rd_q, 16'h0000);
      $display("test mid-run reset done");
      results();
   end
endmodule // entropy_coder_setup_tb
`default_nettype wire
